// file: design/hbgd_host.sv
// Host controller for a two-channel isolated half-bridge gate driver
// Function
// - PWM, fault and temperature travel as signal plus complement pairs.
// - Receivers recover a level by comparing both lines of a pair.
// - Controller inserts its own dead time between the two commands.
// - Controller clears overcurrent with a reset pulse of 500 ns or more.
// - Controller releases supplies before enabling the PWM path.
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module hbgd_host #(
  parameter int TEMP_WIN = hbgd_pkg::TEMP_WIN_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  input wire logic pwm_demand,
  output var logic high_side_gate_cmd_p,
  output var logic high_side_gate_cmd_n,
  output var logic low_side_gate_cmd_p,
  output var logic low_side_gate_cmd_n,
  input wire logic fault_p,
  input wire logic fault_n,
  input wire logic module_temp_freq_out_p,
  input wire logic module_temp_freq_out_n,
  output var logic iso_supply_disable_n,
  output var logic logic_input_enable,
  output var logic fault_reset,
  output var logic irq
);
  import hbgd_pkg::*;

  hbgd_sense_if sense ();

  hbgd_sense #(.TEMP_WIN(TEMP_WIN)) u_sense (
    .clk(clk),
    .sys_rst(sys_rst),
    .fault_p(fault_p),
    .fault_n(fault_n),
    .temp_p(module_temp_freq_out_p),
    .temp_n(module_temp_freq_out_n),
    .sense(sense.src)
  );

  logic [CTRL_W-1:0] ctrl_ff;
  logic [DEAD_W-1:0] dead_ff;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_en_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  hbgd_gate_e state_ff;
  hbgd_gate_e nxt_state;
  hbgd_gate_e target;
  logic [DEAD_W-1:0] dcnt_ff;
  logic [DEAD_W-1:0] nxt_dcnt;
  logic hs_ff;
  logic ls_ff;
  logic supply_ff;
  logic len_ff;
  logic frst_ff;
  logic [RST_W-1:0] rcnt_ff;
  logic fault_ok_d_ff;
  logic irq_ff;

  // Bus decode
  logic access;
  logic wr_en;
  logic rd_take;
  logic hit;
  logic [31:0] rd_mux;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic frst_start;
  logic path_ok;
  logic [IRQ_W-1:0] nxt_irq_en;

  assign access = psel & penable;
  assign wr_en = access & pready_ff & pwrite;
  assign rd_take = access & ~pready_ff;
  assign hit = (paddr == OFS_CTRL) || (paddr == OFS_DEAD) ||
               (paddr == OFS_STAT) || (paddr == OFS_FRST) ||
               (paddr == OFS_TEMP) || (paddr == OFS_IRQ_STAT) ||
               (paddr == OFS_IRQ_EN) || (paddr == OFS_IRQ_CLR);
  assign rd_mux =
    (paddr == OFS_CTRL) ? 32'(ctrl_ff) :
    (paddr == OFS_DEAD) ? 32'(dead_ff) :
    (paddr == OFS_STAT) ? 32'({ls_ff, hs_ff, frst_ff,
                               sense.fault_ok}) :
    (paddr == OFS_TEMP) ? 32'(sense.temp_count) :
    (paddr == OFS_IRQ_STAT) ? 32'(irq_stat_ff) :
    (paddr == OFS_IRQ_EN) ? 32'(irq_en_ff) : 32'h0000_0000;
  assign frst_start = wr_en && (paddr == OFS_FRST) && pwdata[0];
  assign irq_clr = (wr_en && (paddr == OFS_IRQ_CLR)) ?
                   pwdata[IRQ_W-1:0] : '0;
  assign nxt_irq_en = (wr_en && (paddr == OFS_IRQ_EN)) ?
                      pwdata[IRQ_W-1:0] : irq_en_ff;
  assign irq_set = {sense.temp_done,
                    sense.fault_ok & ~fault_ok_d_ff,
                    ~sense.fault_ok & fault_ok_d_ff};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= rd_take;
      pslverr_ff <= rd_take & ~hit;
      if (rd_take) begin
        prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_ff <= CTRL_RESET;
      dead_ff <= DEAD_RESET;
      irq_en_ff <= '0;
    end else if (wr_en) begin
      if (paddr == OFS_CTRL) ctrl_ff <= pwdata[CTRL_W-1:0];
      if (paddr == OFS_DEAD) dead_ff <= pwdata[DEAD_W-1:0];
      if (paddr == OFS_IRQ_EN) irq_en_ff <= pwdata[IRQ_W-1:0];
    end
  end

  // Set beats clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_stat_ff <= '0;
      fault_ok_d_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
      fault_ok_d_ff <= sense.fault_ok;
      // Next enable too, so the line never lags an enable write
      irq_ff <= |(((irq_stat_ff & ~irq_clr) | irq_set) & nxt_irq_en);
    end
  end

  // Enable only follows a released supply; dropping supply drops it too
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      supply_ff <= 1'b0;
      len_ff <= 1'b0;
    end else begin
      supply_ff <= ctrl_ff[CTRL_SUPPLY_BIT];
      len_ff <= ctrl_ff[CTRL_LEN_BIT] & supply_ff &
                ctrl_ff[CTRL_SUPPLY_BIT];
    end
  end

  // Fault reset pulse of fixed minimum width
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      frst_ff <= 1'b0;
      rcnt_ff <= '0;
    end else if (frst_start && !frst_ff) begin
      frst_ff <= 1'b1;
      rcnt_ff <= RST_W'(RST_CYC - 1);
    end else if (frst_ff) begin
      if (rcnt_ff == '0) frst_ff <= 1'b0;
      else rcnt_ff <= rcnt_ff - 1'b1;
    end
  end

  // Gate sequencer: every change of side passes through a dead interval
  assign path_ok = ctrl_ff[CTRL_RUN_BIT] & len_ff & sense.fault_ok;
  assign target = !path_ok ? GS_IDLE : (pwm_demand ? GS_HIGH : GS_LOW);

  always_comb begin
    nxt_state = state_ff;
    nxt_dcnt = dcnt_ff;
    case (state_ff)
      GS_IDLE: begin
        if (target != GS_IDLE) begin
          nxt_state = GS_DEAD;
          nxt_dcnt = dead_ff;
        end
      end
      GS_DEAD: begin
        if (dcnt_ff == '0) nxt_state = target;
        else nxt_dcnt = dcnt_ff - 1'b1;
      end
      GS_HIGH, GS_LOW: begin
        if (target != state_ff) begin
          nxt_state = GS_DEAD;
          nxt_dcnt = dead_ff;
        end
      end
      default: nxt_state = GS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= GS_IDLE;
      dcnt_ff <= '0;
      hs_ff <= 1'b0;
      ls_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      dcnt_ff <= nxt_dcnt;
      hs_ff <= (nxt_state == GS_HIGH);
      ls_ff <= (nxt_state == GS_LOW);
    end
  end

  // Complement lines come from their own flip-flops, loaded with the inverted next state
  logic hs_n_ff;
  logic ls_n_ff;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hs_n_ff <= 1'b1;
      ls_n_ff <= 1'b1;
    end else begin
      hs_n_ff <= ~(nxt_state == GS_HIGH);
      ls_n_ff <= ~(nxt_state == GS_LOW);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign high_side_gate_cmd_p = hs_ff;
  assign high_side_gate_cmd_n = hs_n_ff;
  assign low_side_gate_cmd_p = ls_ff;
  assign low_side_gate_cmd_n = ls_n_ff;
  assign iso_supply_disable_n = supply_ff;
  assign logic_input_enable = len_ff;
  assign fault_reset = frst_ff;
  assign irq = irq_ff;

  // Checking helpers
  logic [DEAD_W:0] gap_cnt;
  logic [RST_W:0] rhi_cnt;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gap_cnt <= '0;
      rhi_cnt <= '0;
    end else begin
      gap_cnt <= (hs_ff | ls_ff) ? '0 : gap_cnt + 1'b1;
      rhi_cnt <= frst_ff ? rhi_cnt + 1'b1 : '0;
    end
  end

  sequence s_side_off;
    !hs_ff && !ls_ff;
  endsequence

  a_diff_compl: assert property (@(posedge clk) disable iff (sys_rst)
    hs_n_ff == !hs_ff && ls_n_ff == !ls_ff)
    else $error("PWM pair lines not complementary");
  a_no_overlap: assert property (@(posedge clk) disable iff (sys_rst)
    !(hs_ff && ls_ff))
    else $error("both gate commands high together");
  a_dead_gap: assert property (@(posedge clk) disable iff (sys_rst)
    s_side_off ##1 (hs_ff || ls_ff) |->
      $past(gap_cnt) >= {1'b0, $past(dead_ff)})
    else $error("dead interval shorter than programmed");
  a_rst_width: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(frst_ff) |-> rhi_cnt >= (RST_W+1)'(RST_CYC))
    else $error("fault reset pulse too short");
  a_rst_start: assert property (@(posedge clk) disable iff (sys_rst)
    frst_start && !frst_ff |=> frst_ff [*8])
    else $error("fault reset pulse not started or held");
  a_len_order: assert property (@(posedge clk) disable iff (sys_rst)
    len_ff |-> supply_ff && $past(supply_ff))
    else $error("logic enable before supply release");
  a_gate_len: assert property (@(posedge clk) disable iff (sys_rst)
    (hs_ff || ls_ff) |-> $past(len_ff))
    else $error("gate command without logic enable");
  a_fault_stop: assert property (@(posedge clk) disable iff (sys_rst)
    !sense.fault_ok |=> s_side_off)
    else $error("gate command kept during reported fault");
  a_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
    |(irq_stat_ff & irq_en_ff) && irq_clr == '0 |-> irq_ff)
    else $error("interrupt low with enabled status set");
endmodule
`default_nettype wire

// file: design/hbgd_pkg.sv
// Constants and types of the half-bridge gate driver host controller
package hbgd_pkg;
  localparam int CLK_PERIOD_PS = 5000;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DEAD = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_FRST = 8'h0c;
  localparam logic [7:0] OFS_TEMP = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h1c;
  // Control fields
  localparam int CTRL_SUPPLY_BIT = 0;
  localparam int CTRL_LEN_BIT = 1;
  localparam int CTRL_RUN_BIT = 2;
  localparam int CTRL_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
  // Status fields
  localparam int STAT_FAULT_OK_BIT = 0;
  localparam int STAT_RST_BUSY_BIT = 1;
  localparam int STAT_HS_BIT = 2;
  localparam int STAT_LS_BIT = 3;
  // Interrupt fields
  localparam int IRQ_FAULT_BIT = 0;
  localparam int IRQ_RECOVER_BIT = 1;
  localparam int IRQ_TEMP_BIT = 2;
  localparam int IRQ_W = 3;
  // Timing
  localparam int DEAD_TIME_NS = 2000;
  localparam int DEAD_W = 16;
  localparam logic [DEAD_W-1:0] DEAD_RESET =
    DEAD_W'((DEAD_TIME_NS * 1000) / CLK_PERIOD_PS);
  localparam int RST_PULSE_NS = 500;
  localparam int RST_CYC =
    (RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RST_W = 8;
  localparam int TEMP_WIN_CYC = 200000;
  localparam int TEMP_CNT_W = 24;
  typedef enum logic [1:0] {GS_IDLE, GS_DEAD, GS_HIGH, GS_LOW} hbgd_gate_e;
endpackage

// file: design/hbgd_sense_if.sv
// Recovered feedback from the driver, passed from receiver to core
`timescale 1ns/1ps
`default_nettype none
interface hbgd_sense_if;
  import hbgd_pkg::*;
  logic fault_ok;
  logic [TEMP_CNT_W-1:0] temp_count;
  logic temp_done;
  modport src (output fault_ok, output temp_count, output temp_done);
  modport dst (input fault_ok, input temp_count, input temp_done);
endinterface
`default_nettype wire

// file: design/hbgd_sense.sv
// Differential feedback receiver with synchroniser and frequency counter
`timescale 1ns/1ps
`default_nettype none
module hbgd_sense #(
  parameter int TEMP_WIN = hbgd_pkg::TEMP_WIN_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic fault_p,
  input wire logic fault_n,
  input wire logic temp_p,
  input wire logic temp_n,
  hbgd_sense_if.src sense
);
  import hbgd_pkg::*;
  localparam int WIN_W = $clog2(TEMP_WIN + 1);
  logic [3:0] raw;
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic temp_prev_ff;
  logic [WIN_W-1:0] win_ff;
  logic [TEMP_CNT_W-1:0] edges_ff;
  logic [TEMP_CNT_W-1:0] count_ff;
  logic done_ff;
  logic temp_rx;
  logic temp_edge;
  logic win_end;

  assign raw = {temp_n, temp_p, fault_n, fault_p};

  // Two stages before any use of the asynchronous feedback
  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        sync1_ff[i] <= 1'b0;
        sync2_ff[i] <= 1'b0;
      end else begin
        sync1_ff[i] <= raw[i];
        sync2_ff[i] <= sync1_ff[i];
      end
    end
  end

  // Equal lines read as fault, so a broken cable stops the bridge
  assign sense.fault_ok = sync2_ff[0] & ~sync2_ff[1];
  assign temp_rx = sync2_ff[2] & ~sync2_ff[3];
  assign temp_edge = temp_rx & ~temp_prev_ff;
  assign win_end = (win_ff == WIN_W'(TEMP_WIN - 1));
  assign sense.temp_count = count_ff;
  assign sense.temp_done = done_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      temp_prev_ff <= 1'b0;
      win_ff <= '0;
      edges_ff <= '0;
      count_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      temp_prev_ff <= temp_rx;
      win_ff <= win_end ? '0 : win_ff + 1'b1;
      done_ff <= win_end;
      if (win_end) begin
        count_ff <= edges_ff + TEMP_CNT_W'(temp_edge);
        edges_ff <= '0;
      end else begin
        edges_ff <= edges_ff + TEMP_CNT_W'(temp_edge);
      end
    end
  end

  a_fault_sync: assert property (@(posedge clk) disable iff (sys_rst)
    (fault_p && !fault_n) [*3] |-> sense.fault_ok)
    else $error("fault not recovered two cycles after stable input");
endmodule
`default_nettype wire

// file: tb/hbgd_drv_model.sv
// Behavioural model of the isolated half-bridge gate driver
`timescale 1ns/1ps
`default_nettype none
module hbgd_drv_model #(
  parameter real HALF_NS = 20.0
) (
  input wire logic hs_p,
  input wire logic hs_n,
  input wire logic ls_p,
  input wire logic ls_n,
  input wire logic iso_supply_disable_n,
  input wire logic logic_input_enable,
  input wire logic fault_reset,
  input wire logic oc_trip,
  input wire logic uv_trip,
  output logic fault_p,
  output logic fault_n,
  output logic temp_p,
  output logic temp_n,
  output logic gate_hs,
  output logic gate_ls
);
  logic hs_in, ls_in, oc_hs, uv_ls, tq;
  realtime rst_t = 0.0;
  initial oc_hs = 1'b0;
  initial tq = 1'b0;
  // Receivers look at the pair, never one line alone
  assign hs_in = logic_input_enable & hs_p & ~hs_n;
  assign ls_in = logic_input_enable & ls_p & ~ls_n;
  // Supplies off collapse the rails, so lockout shows too
  assign uv_ls = ~iso_supply_disable_n | uv_trip;
  assign gate_hs = hs_in & ~ls_in & iso_supply_disable_n & ~oc_hs;
  assign gate_ls = ls_in & ~hs_in & ~uv_ls;
  assign fault_p = iso_supply_disable_n & ~uv_ls & ~oc_hs;
  assign fault_n = ~fault_p;
  assign temp_p = tq;
  assign temp_n = ~tq;
  always #(HALF_NS) tq = ~tq;
  always @(posedge fault_reset) rst_t = $realtime;
  // A pulse too short leaves the latch set
  always @(posedge oc_trip or negedge fault_reset) begin
    if (oc_trip) oc_hs <= 1'b1;
    else if ($realtime - rst_t >= 500.0) oc_hs <= 1'b0;
  end
endmodule
`default_nettype wire

// file: tb/hbgd_host_bench.sv
// Self-checking bench of the gate driver host controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module hbgd_host_bench;
  import hbgd_pkg::*;
  logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr, pwm_demand = 1, oc_trip = 0, uv_trip = 0;
  logic hs_p, hs_n, ls_p, ls_n, f_p, f_n, t_p, t_n;
  logic sup_n, l_en, f_rst, irq, g_hs, g_ls;
  int num_errors = 0, cmp_count = 0, c;
  hbgd_host #(.TEMP_WIN(64)) u_hbgd_host (.clk(clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_demand(pwm_demand), .high_side_gate_cmd_p(hs_p),
    .high_side_gate_cmd_n(hs_n), .low_side_gate_cmd_p(ls_p),
    .low_side_gate_cmd_n(ls_n), .fault_p(f_p), .fault_n(f_n),
    .module_temp_freq_out_p(t_p), .module_temp_freq_out_n(t_n),
    .iso_supply_disable_n(sup_n), .logic_input_enable(l_en),
    .fault_reset(f_rst), .irq(irq));
  hbgd_drv_model u_hbgd_drv_model (.hs_p(hs_p), .hs_n(hs_n), .ls_p(ls_p),
    .ls_n(ls_n), .iso_supply_disable_n(sup_n), .logic_input_enable(l_en),
    .fault_reset(f_rst), .oc_trip(oc_trip), .uv_trip(uv_trip),
    .fault_p(f_p), .fault_n(f_n), .temp_p(t_p), .temp_n(t_n),
    .gate_hs(g_hs), .gate_ls(g_ls));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task give_verdict;
    if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No assumed latency; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdat & m, e)
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Length of a run of reset pulse or of both gates off
  task span(input bit s, output int n);
    n = 0;
    for (int k = 0; k < 400; k++) begin
      @(posedge clk);
      #1;
      if (s ? f_rst === 1'b1 : {hs_p, ls_p} === 2'b00) n++;
      else if (n > 0) break;
    end
  endtask
  always @(posedge clk) begin
    if (!sys_rst) begin
      `CHK({hs_n, ls_n}, ~{hs_p, ls_p})
      `CHK(g_hs & g_ls, 1'b0)
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    `CHK({hs_p, hs_n, ls_p, ls_n, sup_n, l_en, f_rst, irq}, 8'h50)
    rd(OFS_CTRL, 32'hffffffff, 32'h0);
    rd(OFS_DEAD, 32'hffffffff, 32'd400);
    rd(8'h20, 32'hffffffff, 32'h0);
    `CHK(rerr, 1'b1)
    wr(OFS_DEAD, 32'd4);
    wr(OFS_IRQ_EN, 32'h1);
    wr(OFS_CTRL, 32'h7);
    cyc(1);
    `CHK({sup_n, l_en}, 2'b10)
    cyc(40);
    `CHK({hs_p, ls_p, g_hs}, 3'b101)
    rd(OFS_STAT, 32'hf, 32'h5);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      pwm_demand <= (i == 1);
      span(1'b0, c);
      `CHK(c, 5)
    end
    wr(OFS_IRQ_CLR, 32'h7);
    oc_trip <= 1'b1;
    cyc(1);
    oc_trip <= 1'b0;
    cyc(10);
    `CHK({hs_p, ls_p, f_p, irq}, 4'b0001)
    cyc(30);
    rd(OFS_STAT, 32'h1, 32'h0);
    rd(OFS_IRQ_STAT, 32'h1, 32'h1);
    fork
      span(1'b1, c);
      wr(OFS_FRST, 32'h1);
    join
    `CHK(c, RST_CYC)
    cyc(10);
    rd(OFS_STAT, 32'hf, 32'h5);
    rd(OFS_IRQ_STAT, 32'h3, 32'h3);
    wr(OFS_IRQ_CLR, 32'h7);
    cyc(2);
    `CHK(irq, 1'b0)
    // Fault masked from irq by a cleared interrupt enable, with logic enable off
    wr(OFS_IRQ_EN, 32'h0);
    wr(OFS_CTRL, 32'h5);
    cyc(3);
    `CHK({l_en, hs_p, g_hs}, 3'b000)
    uv_trip <= 1'b1;
    cyc(10);
    rd(OFS_STAT, 32'h1, 32'h0);
    rd(OFS_IRQ_STAT, 32'h1, 32'h1);
    `CHK(irq, 1'b0)
    uv_trip <= 1'b0;
    cyc(10);
    rd(OFS_STAT, 32'h1, 32'h1);
    // A full window must pass since the last clear
    cyc(64);
    rd(OFS_IRQ_STAT, 32'h4, 32'h4);
    // 64 cycles of 5 ns hold eight 40 ns model periods
    rd(OFS_TEMP, 32'hffffffff, 32'd8);
    wr(OFS_CTRL, 32'h0);
    cyc(3);
    `CHK({sup_n, l_en, hs_p, ls_p, f_p}, 5'b00000)
    give_verdict;
  end
  initial begin
    #100000;
    num_errors++;
    give_verdict;
  end
endmodule
`default_nettype wire
